//--- cdb_pkg.sv
// Shared constants and types of the divide, logic and branch execution unit
package cdb_pkg;
	localparam int ACC_W = 24;
	localparam int PC_W = 12;
	localparam int NVM_AW = 6;
	localparam int NVM_DEPTH = 64;
	localparam int CFG_WORDS = 16;
	localparam int CFG_BYTES = 48;
	localparam int CFG_LAST_BYTE = 47;
	localparam int BYTES_PER_WORD = 3;
	localparam int CNT_W = 5;
	localparam logic [3:0] CFG_IDX_RST = 4'h0;
	localparam logic [PC_W-1:0] PC_RST = 12'h000;
	localparam logic [ACC_W-1:0] ACC_RST = 24'h000000;
	localparam logic [ACC_W-1:0] ZERO_W = 24'h000000;
	// Cycle counts
	localparam logic [CNT_W-1:0] CYC_FDIV = 5'h14;
	localparam logic [CNT_W-1:0] CYC_MDIV = 5'h14;
	localparam logic [CNT_W-1:0] CYC_LOGIC_ACC = 5'h03;
	localparam logic [CNT_W-1:0] CYC_LOGIC_IMM = 5'h06;
	localparam logic [CNT_W-1:0] CYC_EMBED = 5'h03;
	localparam logic [CNT_W-1:0] CYC_NVLOAD = 5'h06;
	localparam logic [CNT_W-1:0] CYC_TEST = 5'h01;
	localparam logic [CNT_W-1:0] CYC_JMP_REL = 5'h03;
	localparam logic [CNT_W-1:0] CYC_JMP_ABS = 5'h04;
	localparam logic [CNT_W-1:0] CYC_JBITC = 5'h04;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	// Encoded lengths in bytes
	localparam logic [PC_W-1:0] LEN_1 = 12'h001;
	localparam logic [PC_W-1:0] LEN_2 = 12'h002;
	localparam logic [PC_W-1:0] LEN_3 = 12'h003;
	localparam logic [PC_W-1:0] LEN_5 = 12'h005;

	typedef enum logic [3:0] {
		OP_FRACTION_DIVIDE = 4'h0,
		OP_MODULO_DIVIDE = 4'h1,
		OP_XOR = 4'h2,
		OP_XNOR = 4'h3,
		OP_EMBED_CFG = 4'h4,
		OP_NV_LOAD = 4'h5,
		OP_FLAG_TEST = 4'h6,
		OP_JUMP = 4'h7,
		OP_JUMP_IF_BIT_CLEAR = 4'h8,
		OP_JUMP_IF_NONNULL = 4'h9,
		OP_JUMP_IF_NEGATIVE = 4'ha,
		OP_JUMP_IF_POSITIVE = 4'hb,
		OP_JUMP_IF_NO_WRAP = 4'hc,
		OP_JUMP_IF_WRAP = 4'hd
	} cdb_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} cdb_state_t;

	typedef struct packed {
		logic sign;
		logic nonzero;
		logic wrap;
		logic carry;
	} cdb_flags_t;

	typedef struct packed {
		cdb_op_t op;
		logic [1:0] dst;
		logic [1:0] src;
		logic use_imm;
		logic absolute;
		logic [4:0] bit_pos;
		logic [ACC_W-1:0] imm;
		logic [PC_W-1:0] target;
	} cdb_instr_t;
endpackage

//--- cdb_exec.sv
// Execution unit for divide, exclusive logic, nonvolatile access and jump operations
`timescale 1ns/1ps
`default_nettype none

module cdb_exec
	import cdb_pkg::*;
#(
	parameter int NVM_DEPTH_P = NVM_DEPTH
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic instr_valid_i,
	input wire cdb_instr_t instr_i,
	output logic instr_ready_o,
	input wire logic [NVM_AW-1:0] ram_ptr_i,
	input wire logic ext_flags_we_i,
	input wire cdb_flags_t ext_flags_i,
	output logic done_o,
	output logic [PC_W-1:0] pc_o,
	output cdb_flags_t flags_o,
	output logic [3:0][ACC_W-1:0] working_register_o,
	output logic stack_hold_o,
	output logic [3:0] cfg_count_o
);

	// =====================================================
	// State
	typedef struct packed {
		cdb_state_t fsm;
		logic [CNT_W-1:0] cnt;
		logic [3:0][ACC_W-1:0] acc;
		cdb_flags_t flags;
		logic [PC_W-1:0] pc;
		logic [ACC_W-1:0] res1;
		logic [ACC_W-1:0] res2;
		logic [1:0] idx1;
		logic [1:0] idx2;
		logic wr1;
		logic wr2;
		logic wr_flags;
		logic wr_cfg;
		logic nv_load;
		logic [PC_W-1:0] new_pc;
		logic stack_hold;
		logic [3:0] cfg_idx;
		logic done;
	} cdb_st_t;

	cdb_st_t st_r;
	cdb_st_t st_nxt;
	logic [ACC_W-1:0] nvm_mem [NVM_DEPTH_P];

	// =====================================================
	// Helpers
	function automatic cdb_flags_t sz_flags(input cdb_flags_t f, input logic [ACC_W-1:0] v);
		cdb_flags_t r;
		r = f;
		r.sign = v[ACC_W-1];
		r.nonzero = (v != ZERO_W);
		return r;
	endfunction

	logic [ACC_W-1:0] op_a;
	logic [ACC_W-1:0] op_b;
	logic signed [2*ACC_W-1:0] fdiv_q;
	logic signed [ACC_W-1:0] mdiv_q;
	logic signed [ACC_W-1:0] mdiv_r;
	logic [PC_W-1:0] jmp_len;
	logic [PC_W-1:0] jmp_dest;
	logic [CNT_W-1:0] jmp_cyc;
	logic take;

	always_comb begin
		op_a = st_r.acc[instr_i.dst];
		op_b = instr_i.use_imm ? instr_i.imm : st_r.acc[instr_i.src];
		fdiv_q = '0;
		mdiv_q = '0;
		mdiv_r = $signed(op_a);
		if (op_b != ZERO_W) begin
			fdiv_q = $signed({op_a, ZERO_W}) / $signed({{ACC_W{op_b[ACC_W-1]}}, op_b});
			mdiv_q = $signed(op_a) / $signed(op_b);
			mdiv_r = $signed(op_a) % $signed(op_b);
		end
		jmp_len = instr_i.absolute ? LEN_3 : LEN_2;
		jmp_cyc = instr_i.absolute ? CYC_JMP_ABS : CYC_JMP_REL;
		jmp_dest = instr_i.absolute ? instr_i.target : st_r.pc + instr_i.target;
		unique case (instr_i.op)
			OP_JUMP_IF_BIT_CLEAR: take = ~op_a[instr_i.bit_pos];
			OP_JUMP_IF_NONNULL: take = st_r.flags.nonzero;
			OP_JUMP_IF_NEGATIVE: take = st_r.flags.sign;
			OP_JUMP_IF_POSITIVE: take = ~st_r.flags.sign;
			OP_JUMP_IF_NO_WRAP: take = ~st_r.flags.wrap;
			OP_JUMP_IF_WRAP: take = st_r.flags.wrap;
			default: take = 1'b1;
		endcase
	end

	// =====================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (ext_flags_we_i) begin
			st_nxt.flags = ext_flags_i;
		end
		unique case (st_r.fsm)
			ST_IDLE: begin
				if (instr_valid_i) begin
					st_nxt.fsm = ST_EXEC;
					st_nxt.idx1 = instr_i.dst;
					st_nxt.idx2 = instr_i.src;
					st_nxt.wr1 = 1'b0;
					st_nxt.wr2 = 1'b0;
					st_nxt.wr_flags = 1'b0;
					st_nxt.wr_cfg = 1'b0;
					st_nxt.nv_load = 1'b0;
					st_nxt.res1 = op_a;
					st_nxt.res2 = op_b;
					st_nxt.new_pc = st_r.pc + LEN_2;
					st_nxt.cnt = CNT_ONE;
					unique case (instr_i.op)
						OP_FRACTION_DIVIDE: begin
							st_nxt.res1 = fdiv_q[ACC_W-1:0];
							st_nxt.wr1 = 1'b1;
							st_nxt.wr_flags = 1'b1;
							st_nxt.cnt = CYC_FDIV;
						end
						OP_MODULO_DIVIDE: begin
							st_nxt.res1 = mdiv_q;
							st_nxt.res2 = mdiv_r;
							st_nxt.wr1 = 1'b1;
							st_nxt.wr2 = 1'b1;
							st_nxt.wr_flags = 1'b1;
							st_nxt.cnt = CYC_MDIV;
						end
						OP_XOR, OP_XNOR: begin
							st_nxt.res1 = (instr_i.op == OP_XOR) ? (op_a ^ op_b)
								: ~(op_a ^ op_b);
							st_nxt.wr1 = 1'b1;
							st_nxt.wr_flags = 1'b1;
							st_nxt.cnt = instr_i.use_imm ? CYC_LOGIC_IMM : CYC_LOGIC_ACC;
							st_nxt.new_pc = st_r.pc + (instr_i.use_imm ? LEN_5 : LEN_2);
						end
						OP_EMBED_CFG: begin
							st_nxt.res1 = instr_i.imm;
							st_nxt.wr_cfg = 1'b1;
							st_nxt.cnt = CYC_EMBED;
							st_nxt.new_pc = st_r.pc + LEN_3;
						end
						OP_NV_LOAD: begin
							st_nxt.nv_load = 1'b1;
							st_nxt.wr1 = 1'b1;
							st_nxt.wr_flags = 1'b1;
							st_nxt.stack_hold = 1'b1;
							st_nxt.cnt = CYC_NVLOAD;
							st_nxt.new_pc = st_r.pc + LEN_1;
						end
						OP_FLAG_TEST: begin
							st_nxt.wr_flags = 1'b1;
							st_nxt.cnt = CYC_TEST;
							st_nxt.new_pc = st_r.pc + LEN_1;
						end
						OP_JUMP_IF_BIT_CLEAR: begin
							st_nxt.cnt = CYC_JBITC;
							st_nxt.new_pc = take ? instr_i.target : st_r.pc + LEN_3;
						end
						default: begin
							st_nxt.cnt = jmp_cyc;
							st_nxt.new_pc = take ? jmp_dest : st_r.pc + jmp_len;
						end
					endcase
				end
			end
			ST_EXEC: begin
				if (st_r.cnt == CNT_ONE) begin
					st_nxt.fsm = ST_IDLE;
					st_nxt.done = 1'b1;
					st_nxt.pc = st_r.new_pc;
					st_nxt.stack_hold = 1'b0;
					if (st_r.nv_load) begin
						st_nxt.res1 = nvm_mem[ram_ptr_i];
					end
					if (st_r.wr2) begin
						st_nxt.acc[st_r.idx2] = st_r.res2;
					end
					if (st_r.wr1) begin
						st_nxt.acc[st_r.idx1] = st_nxt.res1;
					end
					if (st_r.wr_flags) begin
						st_nxt.flags = sz_flags(st_nxt.flags, st_nxt.acc[st_r.idx1]);
					end
					if (st_r.wr_cfg) begin
						st_nxt.cfg_idx = st_r.cfg_idx + 4'h1;
					end
				end else begin
					st_nxt.cnt = st_r.cnt - CNT_ONE;
				end
			end
			default: st_nxt.fsm = ST_IDLE;
		endcase
	end

	// =====================================================
	// Registers and nonvolatile word store
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_r <= '0;
			st_r.fsm <= ST_IDLE;
			st_r.pc <= PC_RST;
			st_r.cfg_idx <= CFG_IDX_RST;
			st_r.acc <= {4{ACC_RST}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Configuration words fill indices 0..15 (bytes 0..47); code sits above
	always_ff @(posedge clk_i) begin
		if (!srst_i && st_r.fsm == ST_EXEC && st_r.cnt == CNT_ONE && st_r.wr_cfg) begin
			nvm_mem[{2'b00, st_r.cfg_idx}] <= st_r.res1;
		end
	end

	// =====================================================
	// Outputs
	assign instr_ready_o = (st_r.fsm == ST_IDLE);
	assign done_o = st_r.done;
	assign pc_o = st_r.pc;
	assign flags_o = st_r.flags;
	assign working_register_o = st_r.acc;
	assign stack_hold_o = st_r.stack_hold;
	assign cfg_count_o = st_r.cfg_idx;

endmodule // cdb_exec

`default_nettype wire

//--- cdb_exec_checker.sv
// Timing and jump checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none
module cdb_exec_checker
	import cdb_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic instr_valid_i,
	input wire cdb_instr_t instr_i,
	input wire logic instr_ready_o,
	input wire logic done_o,
	input wire logic [PC_W-1:0] pc_o,
	input wire cdb_flags_t flags_o,
	input wire logic stack_hold_o
);
	// ====
	// Sequences
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_take(cdb_op_t o);
		instr_valid_i && instr_ready_o && instr_i.op == o;
	endsequence
	sequence s_commit;
		!instr_ready_o ##1 (instr_ready_o && done_o);
	endsequence
	// ====
	// Assertions
	a_fdiv_timing: assert property (s_take(OP_FRACTION_DIVIDE) |-> ##20 s_commit)
		else $error("fraction divide timing");
	a_xor_imm_timing: assert property (s_take(OP_XOR) ##0 instr_i.use_imm |-> ##6 s_commit)
		else $error("xor constant timing");
	a_xnor_reg_timing: assert property (s_take(OP_XNOR) ##0 !instr_i.use_imm |-> ##3 s_commit)
		else $error("xnor register timing");
	a_load_timing: assert property (s_take(OP_NV_LOAD) |-> ##6 s_commit)
		else $error("load timing");
	a_load_hold: assert property (s_take(OP_NV_LOAD) |=> stack_hold_o [*6])
		else $error("stack entry not held");
	a_test_timing: assert property (s_take(OP_FLAG_TEST) |-> ##1 s_commit)
		else $error("flag test timing");
	a_bitc_timing: assert property (s_take(OP_JUMP_IF_BIT_CLEAR) |-> ##4 s_commit)
		else $error("bit clear jump timing");
	a_jump_dest: assert property (s_take(OP_JUMP) ##0 instr_i.absolute |-> ##5 pc_o == $past(instr_i.target, 5))
		else $error("jump target not loaded");
	a_jump_flags: assert property (instr_valid_i && instr_ready_o && instr_i.op >= OP_JUMP_IF_BIT_CLEAR |=> $stable(flags_o) [*5])
		else $error("jump changed flags");
endmodule // cdb_exec_checker
bind cdb_exec cdb_exec_checker u_chk (.clk_i, .srst_i, .instr_valid_i, .instr_i, .instr_ready_o,
	.done_o, .pc_o, .flags_o, .stack_hold_o);
`default_nettype wire

//--- tb_cpu_divide_logic_branch_ops.sv
// Self-checking bench of the execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_divide_logic_branch_ops
	import cdb_pkg::*;
;
	typedef struct packed {logic [PC_W-1:0] p; cdb_flags_t f; logic [3:0][ACC_W-1:0] r; logic [3:0] c;} cdb_exp_t;
	logic clk_i, srst_i, vld, we, rdy, done, hold;
	cdb_instr_t ins;
	cdb_flags_t ef, fl;
	logic [5:0] ptr;
	logic [PC_W-1:0] pc;
	logic [3:0][ACC_W-1:0] wr;
	logic [3:0] cfg;
	logic [ACC_W-1:0] w [16];
	cdb_exp_t q [$];
	cdb_exp_t m;
	cdb_exp_t e;
	int num_errors = 0, checked = 0, seed = 49;
	cdb_exec DUT (.clk_i, .srst_i, .instr_valid_i(vld), .instr_i(ins), .instr_ready_o(rdy),
		.ram_ptr_i(ptr), .ext_flags_we_i(we), .ext_flags_i(ef), .done_o(done), .pc_o(pc),
		.flags_o(fl), .working_register_o(wr), .stack_hold_o(hold), .cfg_count_o(cfg));
	// ====
	// Tasks
	task automatic chk(string n, logic [127:0] s, logic [127:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic go(cdb_op_t o, int d, int s, logic im, logic ab, logic [23:0] v, logic [11:0] t);
		logic signed [47:0] x;
		logic [23:0] a, b;
		logic c;
		@(negedge clk_i) ins = '{o, 2'(d), 2'(s), im, ab, v[4:0], v, t};
		a = m.r[d];
		b = im ? v : m.r[s];
		c = 1;
		case (o)
			OP_FRACTION_DIVIDE: begin
				x = $signed({a, 24'h0}) / $signed(b);
				m.r[d] = x[23:0];
			end
			OP_MODULO_DIVIDE: begin
				m.r[s] = b ? $signed(a) % $signed(b) : $signed(a);
				m.r[d] = b ? $signed(a) / $signed(b) : 0;
			end
			OP_XOR: m.r[d] = a ^ b;
			OP_XNOR: m.r[d] = ~(a ^ b);
			OP_EMBED_CFG: begin
				w[m.c] = v;
				m.c++;
			end
			OP_NV_LOAD: m.r[d] = w[ptr];
			OP_JUMP_IF_BIT_CLEAR: c = !a[v[4:0]];
			OP_JUMP_IF_NONNULL: c = m.f.nonzero;
			OP_JUMP_IF_NEGATIVE: c = m.f.sign;
			OP_JUMP_IF_POSITIVE: c = !m.f.sign;
			OP_JUMP_IF_NO_WRAP: c = !m.f.wrap;
			OP_JUMP_IF_WRAP: c = m.f.wrap;
			default: c = 1;
		endcase
		if (o < OP_EMBED_CFG || o == OP_NV_LOAD || o == OP_FLAG_TEST) begin
			m.f.sign = m.r[d][23];
			m.f.nonzero = |m.r[d];
		end
		ab = ab || o == OP_JUMP_IF_BIT_CLEAR;
		if (o >= OP_JUMP) m.p = c ? (ab ? t : m.p + t) : m.p + (ab ? LEN_3 : LEN_2);
		else m.p += o > OP_EMBED_CFG ? LEN_1 : o == OP_EMBED_CFG ? LEN_3 : im ? LEN_5 : LEN_2;
		q.push_back(m);
		vld = 1;
		@(negedge clk_i) vld = 0;
		for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge clk_i);
	endtask
	task automatic ld(int d, logic [23:0] v);
		go(OP_XOR, d, d, 0, 0, 0, 0);
		go(OP_XOR, d, 0, 1, 0, v, 0);
	endtask
	task automatic setf(cdb_flags_t f);
		@(negedge clk_i) begin
			we = 1;
			ef = f;
		end
		@(negedge clk_i) we = 0;
		m.f = f;
	endtask
	// ====
	// Clock, monitor and watchdog
	initial begin
		clk_i = 0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		if (done === 1'b1) begin
			e = q.size() ? q.pop_front() : 'x;
			chk("pc", pc, e.p);
			chk("flags", fl, e.f);
			chk("regs", {wr, cfg}, {e.r, e.c});
			chk("hold", hold, 1'b0);
		end
	end
	initial begin
		#(25ns * 20000);
		num_errors++;
		tally_and_finish();
	end
	// ====
	// Scenarios
	initial begin
		srst_i = 1;
		{vld, we, ef, ins, ptr, m} = '0;
		repeat (8) @(posedge clk_i);
		@(negedge clk_i) srst_i = 0;
		chk("reset_hs", {rdy, done, hold}, 3'b100);
		chk("reset_state", {pc, fl, wr, cfg}, {PC_RST, 4'h0, {4{ACC_RST}}, CFG_IDX_RST});
		for (int i = 0; i < 16; i++) go(OP_EMBED_CFG, 0, 0, 1, 0, 24'($random(seed)), 0);
		for (int i = 0; i < 4; i++) begin
			ptr = 6'($unsigned($random(seed)) % 16);
			go(OP_NV_LOAD, i, 0, 0, 0, 0, 0);
			go(OP_FLAG_TEST, i, 0, 0, 0, 0, 0);
		end
		for (int i = 0; i < 24; i++) go(i % 2 ? OP_XNOR : OP_XOR, i % 4, (i / 4) % 4, i[2], 0, 24'($random(seed)), 0);
		ld(0, 24'hfff830);
		ld(1, 24'h00c350);
		go(OP_FRACTION_DIVIDE, 0, 1, 0, 0, 0, 0);
		ld(2, 24'hfffc18);
		ld(3, 24'h000007);
		go(OP_MODULO_DIVIDE, 2, 3, 0, 0, 0, 0);
		ld(0, 24'h000000);
		go(OP_MODULO_DIVIDE, 2, 0, 0, 0, 0, 0);
		for (int o = 7; o < 14; o++) begin
			for (int k = 0; k < 4; k++) begin
				setf({k[1], k[1], k[1], k[0]});
				go(cdb_op_t'(o), k, 0, 0, k[0], 24'($unsigned($random(seed)) % 24), 12'($random(seed)));
			end
		end
		repeat (4) @(negedge clk_i);
		chk("pending", q.size(), 0);
		tally_and_finish();
	end
endmodule // tb_cpu_divide_logic_branch_ops
`default_nettype wire
